// ===== verilog/pmfis_top.sv
// Purpose: privileged-mode fetch/issue synchronisation and prediction control
// Assumes: pipeline reports retire, fetch, issue and load events on the core clock
// Notes:   registers reached over AXI4-Lite; one write and one read at a time
// Summary of operation
// [RULE1] control register updates at nontrapping write retire
// [RULE2] fp ops wait four cycles after write
// [RULE3] icache off: supply only stream-buffer hits
// [RULE4] icache flush waits for stall return, fetch idle
// [RULE5] stall return after map clear never flushes
// [RULE6] firmware keeps flush write apart from return
// [RULE7] return fetch may leave privileged mode speculatively
// [RULE8] firmware invalidates itlb early after reset
// [RULE9] privileged cond branches not taken, except first fetch
// [RULE10] unprivileged jumps in privileged mode always mispredict
// [RULE11] stack predicts only native-mode return targets
// [RULE12] trap pushes exception address onto stack
// [RULE13] privileged jumps predicted from hint and mode
// [RULE14] register moves held on store-bubble busy
// [RULE15] physical load leaves fault status unchanged
// [RULE16] firmware barriers loads after fault status read
// [RULE17] firmware chains asn/istream writes behind scoreboard
// [RULE18] asn and istream writes retire in pairs
// [RULE19] stall return drains pipeline for register updates
//
// The address map and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module pmfis_top (
  input  wire logic                           clock,
  input  wire logic                           rst,
  // AXI4-Lite slave
  input  wire logic                           s_axi_awvalid,
  output logic                                s_axi_awready,
  input  wire logic [7:0]                     s_axi_awaddr,
  input  wire logic                           s_axi_wvalid,
  output logic                                s_axi_wready,
  input  wire logic [31:0]                    s_axi_wdata,
  input  wire logic [3:0]                     s_axi_wstrb,
  output logic                                s_axi_bvalid,
  input  wire logic                           s_axi_bready,
  output logic      [1:0]                     s_axi_bresp,
  input  wire logic                           s_axi_arvalid,
  output logic                                s_axi_arready,
  input  wire logic [7:0]                     s_axi_araddr,
  output logic                                s_axi_rvalid,
  input  wire logic                           s_axi_rready,
  output logic      [31:0]                    s_axi_rdata,
  output logic      [1:0]                     s_axi_rresp,
  // pipeline
  input  wire pmfis_pkg::pmfis_retire_t       retireEvt,
  input  wire logic                           privMode,
  input  wire logic                           stallRetRetire,
  input  wire logic                           fetchOutstanding,
  input  wire logic                           fpOpReq,
  output logic                                fpOpGo,
  output logic                                icacheFlush,
  output logic                                pairAbort,
  input  wire logic                           streamHit,
  input  wire logic                           icacheHit,
  output logic                                supplyValid,
  input  wire pmfis_pkg::pmfis_branch_t       branchIn,
  output pmfis_pkg::pmfis_predict_t           predictOut,
  output logic                                specExitAllowed,
  input  wire logic                           trapEnter,
  input  wire logic [pmfis_pkg::ADDR_W-1:0]   exceptionAddress,
  input  wire logic                           irMoveReq,
  input  wire logic                           loadReq,
  input  wire logic                           storeBubbleBusy,
  input  wire logic                           loadBubbleBusy,
  output logic                                irMoveIssue,
  output logic                                loadIssue,
  input  wire pmfis_pkg::pmfis_load_t         loadDone,
  output logic                                pipeDrain
);
  // register state
  logic [31:0] ctrl, next_ctrl;
  logic [31:0] fpControl, next_fpControl;
  logic [31:0] faultStatus, next_faultStatus;
  logic [31:0] faultAddr, next_faultAddr;
  logic [31:0] faultForm, next_faultForm;
  logic [31:0] dcControl, next_dcControl;
  logic        flushPend, next_flushPend;
  logic        flushArmed, next_flushArmed;
  logic        itlbInit, next_itlbInit;
  logic [2:0]  fpWait, next_fpWait;
  logic        pairOpen, next_pairOpen;

  logic wrFire, rdFire, retNative;
  logic [pmfis_pkg::ADDR_W-1:0] rasTop;

  // register bus slave
  logic        awHeld, next_awHeld, wHeld, next_wHeld;
  logic [7:0]  awAddr, next_awAddr;
  logic [31:0] wData, next_wData;
  logic        bv, next_bv, rv, next_rv;
  logic [1:0]  bresp, next_bresp, rresp, next_rresp;
  logic [31:0] rdata, next_rdata;

  assign s_axi_awready = !awHeld && !bv;
  assign s_axi_wready  = !wHeld && !bv;
  assign s_axi_arready = !rv;
  assign s_axi_bvalid  = bv;
  assign s_axi_bresp   = bresp;
  assign s_axi_rvalid  = rv;
  assign s_axi_rdata   = rdata;
  assign s_axi_rresp   = rresp;
  assign wrFire = awHeld && wHeld && !bv;
  assign rdFire = s_axi_arvalid && !rv;

  always_comb begin
    next_awHeld = awHeld;
    next_wHeld  = wHeld;
    next_awAddr = awAddr;
    next_wData  = wData;
    next_bv     = bv;
    next_bresp  = bresp;
    next_rv     = rv;
    next_rresp  = rresp;
    next_rdata  = rdata;
    if (s_axi_awvalid && s_axi_awready) begin
      next_awHeld = 1'b1;
      next_awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_wHeld = 1'b1;
      next_wData = s_axi_wdata;
    end
    if (wrFire) begin
      next_awHeld = 1'b0;
      next_wHeld  = 1'b0;
      next_bv     = 1'b1;
      next_bresp  = (awAddr == pmfis_pkg::REG_CTRL) ? pmfis_pkg::RESP_OKAY
                                                    : pmfis_pkg::RESP_SLVERR;
    end else if (bv && s_axi_bready) begin
      next_bv = 1'b0;
    end
    if (rdFire) begin
      next_rv    = 1'b1;
      next_rresp = pmfis_pkg::RESP_OKAY;
      case (s_axi_araddr)
        pmfis_pkg::REG_CTRL:   next_rdata = ctrl;
        pmfis_pkg::REG_STATUS: next_rdata = {27'h0, privMode, pairOpen, (fpWait == 3'h0),
                                             itlbInit, flushPend};
        pmfis_pkg::REG_FPCTL:  next_rdata = fpControl;
        pmfis_pkg::REG_FAULT:  next_rdata = faultStatus;
        pmfis_pkg::REG_FADDR:  next_rdata = faultAddr;
        pmfis_pkg::REG_FFORM:  next_rdata = faultForm;
        pmfis_pkg::REG_DCCTL:  next_rdata = dcControl;
        pmfis_pkg::REG_RASTOP: next_rdata = rasTop;
        default: begin
          next_rdata = 32'h0;
          next_rresp = pmfis_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rv && s_axi_rready) begin
      next_rv = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      awHeld <= 1'b0;
      wHeld  <= 1'b0;
      awAddr <= 8'h0;
      wData  <= 32'h0;
      bv     <= 1'b0;
      bresp  <= 2'h0;
      rv     <= 1'b0;
      rresp  <= 2'h0;
      rdata  <= 32'h0;
    end else begin
      awHeld <= next_awHeld;
      wHeld  <= next_wHeld;
      awAddr <= next_awAddr;
      wData  <= next_wData;
      bv     <= next_bv;
      bresp  <= next_bresp;
      rv     <= next_rv;
      rresp  <= next_rresp;
      rdata  <= next_rdata;
    end
  end

  // sync, flush, pair and fault state
  logic retV;
  assign retV = retireEvt.valid;

  always_comb begin
    next_ctrl        = ctrl;
    next_fpControl   = fpControl;
    next_faultStatus = faultStatus;
    next_faultAddr   = faultAddr;
    next_faultForm   = faultForm;
    next_dcControl   = dcControl;
    next_flushPend   = flushPend;
    next_flushArmed  = flushArmed;
    next_itlbInit    = itlbInit;
    next_fpWait      = (fpWait != 3'h0) ? fpWait - 3'h1 : 3'h0;
    next_pairOpen    = pairOpen;
    if (wrFire && awAddr == pmfis_pkg::REG_CTRL && s_axi_wstrb[0]) begin
      next_ctrl = {30'h0, wData[pmfis_pkg::CTRL_SB_EN], wData[pmfis_pkg::CTRL_ICACHE_EN]};
    end
    // flush becomes eligible only at a later stall return
    if (flushArmed && stallRetRetire) begin
      next_flushArmed = 1'b0;
      next_flushPend  = 1'b1; // [RULE4]
    end
    if (flushPend && !fetchOutstanding) begin
      next_flushPend = 1'b0; // [RULE4]
    end
    if (pairOpen && stallRetRetire) begin
      next_pairOpen = 1'b0; // [RULE18]
    end
    if (retV && !retireEvt.trapping) begin
      case (retireEvt.kind)
        pmfis_pkg::PMFIS_IRW_FPCTL: begin
          next_fpControl = retireEvt.data; // [RULE1]
          next_fpWait    = pmfis_pkg::FP_LATENCY; // [RULE2]
        end
        pmfis_pkg::PMFIS_IRW_IFLUSH,
        pmfis_pkg::PMFIS_IRW_ASFLUSH: next_flushArmed = 1'b1; // [RULE4]
        pmfis_pkg::PMFIS_IRW_MAPCLR:  next_flushArmed = 1'b0; // [RULE5]
        pmfis_pkg::PMFIS_IRW_ITLBIA:  next_itlbInit = 1'b1;
        pmfis_pkg::PMFIS_IRW_ASN_A,
        pmfis_pkg::PMFIS_IRW_IS_A: begin
          next_pairOpen = 1'b1; // [RULE18]
        end
        pmfis_pkg::PMFIS_IRW_ASN_B,
        pmfis_pkg::PMFIS_IRW_IS_B: next_pairOpen = 1'b0; // [RULE18]
        default: ;
      endcase
    end
    if (loadDone.valid) begin
      if (!loadDone.physical) begin
        next_faultStatus = loadDone.status; // [RULE15]
      end
      next_faultAddr = loadDone.address;
      next_faultForm = loadDone.formatted;
      next_dcControl = loadDone.dcControl;
    end
  end

  // a broken pair aborts
  always_comb begin
    pairAbort = 1'b0;
    if (pairOpen && stallRetRetire) begin
      pairAbort = 1'b1; // [RULE18]
    end
    if (pairOpen && retV && !retireEvt.trapping &&
        retireEvt.kind != pmfis_pkg::PMFIS_IRW_ASN_B &&
        retireEvt.kind != pmfis_pkg::PMFIS_IRW_IS_B &&
        retireEvt.kind != pmfis_pkg::PMFIS_IRW_NONE) begin
      pairAbort = 1'b1; // [RULE18]
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl        <= pmfis_pkg::CTRL_RESET;
      fpControl   <= 32'h0;
      faultStatus <= 32'h0;
      faultAddr   <= 32'h0;
      faultForm   <= 32'h0;
      dcControl   <= 32'h0;
      flushPend   <= 1'b0;
      flushArmed  <= 1'b0;
      itlbInit    <= 1'b0;
      fpWait      <= 3'h0;
      pairOpen    <= 1'b0;
    end else begin
      ctrl        <= next_ctrl;
      fpControl   <= next_fpControl;
      faultStatus <= next_faultStatus;
      faultAddr   <= next_faultAddr;
      faultForm   <= next_faultForm;
      dcControl   <= next_dcControl;
      flushPend   <= next_flushPend;
      flushArmed  <= next_flushArmed;
      itlbInit    <= next_itlbInit;
      fpWait      <= next_fpWait;
      pairOpen    <= next_pairOpen;
    end
  end

  assign icacheFlush = flushPend && !fetchOutstanding; // [RULE4]
  assign fpOpGo      = fpOpReq && (fpWait == 3'h0); // [RULE2]
  assign pipeDrain   = stallRetRetire; // [RULE19]
  assign specExitAllowed = 1'b1; // [RULE7]

  // instruction supply
  assign supplyValid = ctrl[pmfis_pkg::CTRL_ICACHE_EN] ? (icacheHit || streamHit)
                                                       : streamHit; // [RULE3]

  // issue ordering
  assign irMoveIssue = irMoveReq && !storeBubbleBusy; // [RULE14]
  assign loadIssue   = loadReq && !loadBubbleBusy; // [RULE14]

  // prediction
  assign retNative = branchIn.valid && branchIn.kind == pmfis_pkg::PMFIS_BR_PRET &&
                     !branchIn.targetPriv;

  pmfis_ras u_ras (
    .clock    (clock),
    .rst      (rst),
    .push     (trapEnter), // [RULE12]
    .pushAddr (exceptionAddress),
    .pop      (retNative),
    .top      (rasTop)
  );

  always_comb begin
    predictOut = '0;
    if (branchIn.valid && privMode) begin
      case (branchIn.kind)
        pmfis_pkg::PMFIS_BR_COND: begin
          predictOut.taken = !branchIn.callPal &&
                             (branchIn.flowSlot < pmfis_pkg::FIRST_FETCH); // [RULE9]
        end
        pmfis_pkg::PMFIS_BR_UJUMP: predictOut.mispredict = 1'b1; // [RULE10]
        pmfis_pkg::PMFIS_BR_PRET: begin
          predictOut.taken = 1'b1;
          if (branchIn.targetPriv) begin
            predictOut.mispredict = 1'b1; // [RULE11]
          end else begin
            predictOut.fromStack = 1'b1; // [RULE11]
            predictOut.target    = rasTop;
          end
        end
        pmfis_pkg::PMFIS_BR_PJUMP,
        pmfis_pkg::PMFIS_BR_PCALL,
        pmfis_pkg::PMFIS_BR_PCORO: begin
          predictOut.taken  = 1'b1;
          predictOut.target = {branchIn.target[31:2], branchIn.hint[0],
                               branchIn.targetPriv}; // [RULE13]
        end
        default: ;
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== verilog/pmfis_pkg.sv
// Purpose: shared types and constants for the privileged-mode fetch/issue sync block
// Assumes: one core clock at 250 MHz, synchronous active-high reset
// Notes:   register offsets are byte addresses on the AXI4-Lite slave
package pmfis_pkg;

  localparam logic [2:0]  FP_LATENCY      = 3'h4;
  localparam logic [2:0]  FIRST_FETCH     = 3'h4;
  localparam int unsigned RAS_DEPTH       = 8;
  localparam int unsigned RAS_PTR_W       = 3;
  localparam int unsigned ADDR_W          = 32;

  // register map
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_STATUS   = 8'h04;
  localparam logic [7:0] REG_FPCTL    = 8'h08;
  localparam logic [7:0] REG_FAULT    = 8'h0c;
  localparam logic [7:0] REG_FADDR    = 8'h10;
  localparam logic [7:0] REG_FFORM    = 8'h14;
  localparam logic [7:0] REG_DCCTL    = 8'h18;
  localparam logic [7:0] REG_RASTOP   = 8'h1c;

  // ctrl bits
  localparam int unsigned CTRL_ICACHE_EN = 0;
  localparam int unsigned CTRL_SB_EN     = 1;
  localparam logic [31:0] CTRL_RESET     = 32'h0000_0001;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    PMFIS_IRW_NONE    = 4'h0,
    PMFIS_IRW_FPCTL   = 4'h1,
    PMFIS_IRW_IFLUSH  = 4'h2,
    PMFIS_IRW_ASFLUSH = 4'h3,
    PMFIS_IRW_MAPCLR  = 4'h4,
    PMFIS_IRW_ITLBIA  = 4'h5,
    PMFIS_IRW_ASN_A   = 4'h6,
    PMFIS_IRW_ASN_B   = 4'h7,
    PMFIS_IRW_IS_A    = 4'h8,
    PMFIS_IRW_IS_B    = 4'h9
  } pmfis_irw_t;

  typedef enum logic [3:0] {
    PMFIS_BR_NONE    = 4'h0,
    PMFIS_BR_COND    = 4'h1,
    PMFIS_BR_UJUMP   = 4'h2,
    PMFIS_BR_PRET    = 4'h3,
    PMFIS_BR_PJUMP   = 4'h4,
    PMFIS_BR_PCALL   = 4'h5,
    PMFIS_BR_PCORO   = 4'h6
  } pmfis_br_t;

  typedef struct packed {
    logic        valid;
    logic        trapping;
    pmfis_irw_t  kind;
    logic [31:0] data;
  } pmfis_retire_t;

  typedef struct packed {
    logic              valid;
    pmfis_br_t         kind;
    logic              stall;
    logic              callPal;
    logic [2:0]        flowSlot;
    logic              targetPriv;
    logic [1:0]        hint;
    logic [ADDR_W-1:0] target;
  } pmfis_branch_t;

  typedef struct packed {
    logic              taken;
    logic              mispredict;
    logic              fromStack;
    logic [ADDR_W-1:0] target;
  } pmfis_predict_t;

  typedef struct packed {
    logic        valid;
    logic        physical;
    logic [31:0] status;
    logic [31:0] address;
    logic [31:0] formatted;
    logic [31:0] dcControl;
  } pmfis_load_t;

endpackage

// ===== verilog/pmfis_ras.sv
// Purpose: return-address stack for native-mode return prediction
// Assumes: push and pop never in the same cycle with an empty stack
// Notes:   wraps on overflow, oldest entry lost
`timescale 1ns/100ps
`default_nettype none
module pmfis_ras (
  input  wire logic                          clock,
  input  wire logic                          rst,
  input  wire logic                          push,
  input  wire logic [pmfis_pkg::ADDR_W-1:0]  pushAddr,
  input  wire logic                          pop,
  output logic      [pmfis_pkg::ADDR_W-1:0]  top
);
  logic [pmfis_pkg::ADDR_W-1:0]    stack [pmfis_pkg::RAS_DEPTH];
  logic [pmfis_pkg::RAS_PTR_W-1:0] ptr;
  logic [pmfis_pkg::RAS_PTR_W-1:0] next_ptr;

  always_comb begin
    next_ptr = ptr;
    if (push && !pop) begin
      next_ptr = ptr + 3'h1;
    end else if (pop && !push) begin
      next_ptr = ptr - 3'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      ptr <= '0;
    end else begin
      ptr <= next_ptr;
    end
  end

  always_ff @(posedge clock) begin
    if (push && !pop) begin
      stack[ptr] <= pushAddr;
    end else if (push && pop) begin
      stack[ptr - 3'h1] <= pushAddr;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      top <= '0;
    end else if (push) begin
      top <= pushAddr;
    end else if (pop) begin
      top <= stack[ptr - 3'h2];
    end
  end
endmodule
`default_nettype wire

// ===== bench/pmfis_top_chk.sv
// Purpose: assertion checker for the fetch/issue sync top
// Assumes: one core clock, synchronous active-high reset
// Notes:   bound to every pmfis_top instance
`timescale 1ns/100ps
`default_nettype none
module pmfis_top_chk (
  input wire logic                      clock,
  input wire logic                      rst,
  input wire pmfis_pkg::pmfis_retire_t  retireEvt,
  input wire logic                      privMode,
  input wire logic                      stallRetRetire,
  input wire logic                      fetchOutstanding,
  input wire logic                      fpOpReq,
  input wire logic                      fpOpGo,
  input wire logic                      icacheFlush,
  input wire logic                      pairAbort,
  input wire logic                      streamHit,
  input wire logic                      icacheHit,
  input wire logic                      supplyValid,
  input wire pmfis_pkg::pmfis_branch_t  branchIn,
  input wire pmfis_pkg::pmfis_predict_t predictOut,
  input wire logic                      loadReq,
  input wire logic                      storeBubbleBusy,
  input wire logic                      loadBubbleBusy,
  input wire logic                      irMoveIssue,
  input wire logic                      loadIssue,
  input wire logic                      pipeDrain
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic fpRet, pairStart, privBr;
  assign fpRet = retireEvt.valid && !retireEvt.trapping
                 && retireEvt.kind == pmfis_pkg::PMFIS_IRW_FPCTL;
  assign pairStart = retireEvt.valid && !retireEvt.trapping
                     && (retireEvt.kind == pmfis_pkg::PMFIS_IRW_ASN_A
                         || retireEvt.kind == pmfis_pkg::PMFIS_IRW_IS_A);
  assign privBr = branchIn.valid && privMode;
  fp_hold_a : assert property (fpRet |=> (!fpOpGo)[*4])
    else $error("fp op released early");
  fp_release_a : assert property (fpRet ##1 (!fpRet)[*4] |=> (fpOpReq |-> fpOpGo))
    else $error("fp op held late");
  flush_idle_a : assert property (fetchOutstanding |-> !icacheFlush)
    else $error("flush with fetch busy");
  flush_once_a : assert property (icacheFlush |=> !icacheFlush)
    else $error("flush longer than one cycle");
  pair_abort_a : assert property (pairStart ##1 (!retireEvt.valid)[*2]
    ##1 (stallRetRetire && !retireEvt.valid) |-> pairAbort) else $error("half pair not aborted");
  drain_stall_a : assert property (pipeDrain == stallRetRetire)
    else $error("drain mismatch");
  cond_nottaken_a : assert property (privBr && branchIn.kind == pmfis_pkg::PMFIS_BR_COND
    && (branchIn.callPal || branchIn.flowSlot >= 3'h4) |-> !predictOut.taken) else $error("cond taken");
  ujump_miss_a : assert property (privBr
    && branchIn.kind == pmfis_pkg::PMFIS_BR_UJUMP |-> predictOut.mispredict) else $error("ujump");
  pret_priv_a : assert property (privBr && branchIn.kind == pmfis_pkg::PMFIS_BR_PRET
    && branchIn.targetPriv |-> predictOut.mispredict && !predictOut.fromStack) else $error("pret");
  irmove_hold_a : assert property (storeBubbleBusy |-> !irMoveIssue)
    else $error("move issued busy");
  load_free_a : assert property (loadReq && !loadBubbleBusy |-> loadIssue)
    else $error("load held");
  supply_src_a : assert property (!streamHit && !icacheHit |-> !supplyValid)
    else $error("supply without a hit");
endmodule
bind pmfis_top pmfis_top_chk chk_u (.*);
`default_nettype wire

// ===== bench/privileged_mode_fetch_issue_sync_bench.sv
// Purpose: self-checking bench for the fetch/issue sync top
// Assumes: bus tasks are entered just after a rising or a falling edge
// Notes:   pipeline events are one-cycle pulses
`timescale 1ns/100ps
`default_nettype none
module privileged_mode_fetch_issue_sync_bench;
  logic                      clock, rst;
  logic                      s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic                      s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic                      s_axi_rvalid, s_axi_rready;
  logic [7:0]                s_axi_awaddr, s_axi_araddr;
  logic [31:0]               s_axi_wdata, s_axi_rdata, exceptionAddress, rd, n;
  logic [3:0]                s_axi_wstrb;
  logic [1:0]                s_axi_bresp, s_axi_rresp, rr;
  pmfis_pkg::pmfis_retire_t  retireEvt;
  pmfis_pkg::pmfis_branch_t  branchIn;
  pmfis_pkg::pmfis_predict_t predictOut;
  pmfis_pkg::pmfis_load_t    loadDone;
  logic                      privMode, stallRetRetire, fetchOutstanding, fpOpReq, fpOpGo;
  logic                      icacheFlush, pairAbort, streamHit, icacheHit, supplyValid;
  logic                      specExitAllowed, trapEnter, irMoveReq, loadReq, storeBubbleBusy;
  logic                      loadBubbleBusy, irMoveIssue, loadIssue, pipeDrain;
  int                        mismatches, checkCount;

  pmfis_top dut_u (.*);

  always #2 clock = ~clock;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic chk1(input logic seen, input logic exp);
    check({31'h0, seen}, {31'h0, exp});
  endtask
  task automatic conclude();
    if (mismatches == 0 && checkCount > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aHit, wHit, bHit;
    @(posedge clock);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    bHit = 1'b0;
    while (!bHit) begin
      @(negedge clock);
      aHit = s_axi_awvalid && s_axi_awready;
      wHit = s_axi_wvalid && s_axi_wready;
      bHit = s_axi_bvalid;
      rr   = s_axi_bresp;
      @(posedge clock);
      if (aHit)
        s_axi_awvalid <= 1'b0;
      if (wHit)
        s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    check({30'h0, rr}, {30'h0, er});
  endtask
  task automatic axiRead(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                         input logic [1:0] er);
    logic arHit, rHit;
    @(posedge clock);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    rHit = 1'b0;
    while (!rHit) begin
      @(negedge clock);
      arHit = s_axi_arvalid && s_axi_arready;
      rHit  = s_axi_rvalid;
      rd    = s_axi_rdata;
      rr    = s_axi_rresp;
      @(posedge clock);
      if (arHit)
        s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    check(rd & m, e);
    check({30'h0, rr}, {30'h0, er});
  endtask

  task automatic retire(input pmfis_pkg::pmfis_irw_t k, input logic trap, input logic [31:0] d);
    @(posedge clock);
    retireEvt <= '{1'b1, trap, k, d};
    @(posedge clock);
    retireEvt <= '0;
  endtask
  task automatic stallRet(input logic abort);
    repeat (2) @(posedge clock);
    stallRetRetire <= 1'b1;
    @(negedge clock);
    chk1(pipeDrain, 1'b1);
    chk1(pairAbort, abort);
    @(posedge clock);
    stallRetRetire <= 1'b0;
  endtask
  task automatic flushes(input logic [31:0] e);
    n = 32'h0;
    repeat (3) begin
      @(negedge clock);
      n = n + {31'h0, icacheFlush};
    end
    check(n, e);
  endtask
  task automatic br(input pmfis_pkg::pmfis_br_t k, input logic [2:0] s, input logic cp,
                    input logic tp);
    @(posedge clock);
    branchIn <= '{1'b1, k, 1'b0, cp, s, tp, 2'h1, 32'h1000_0000};
    @(negedge clock);
  endtask
  task automatic ld(input logic p, input logic [31:0] v);
    @(posedge clock);
    loadDone <= '{1'b1, p, v, v, v, v};
    @(posedge clock);
    loadDone <= '0;
  endtask

  initial begin
    repeat (5000) @(posedge clock);
    mismatches++;
    conclude();
  end

  initial begin
    clock = 1'b0;
    rst = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awaddr,
     s_axi_araddr, s_axi_wdata, exceptionAddress, stallRetRetire, fetchOutstanding, fpOpReq,
     streamHit, icacheHit, trapEnter, irMoveReq, loadReq, storeBubbleBusy, loadBubbleBusy} = '0;
    s_axi_wstrb = 4'hf;
    retireEvt = '0;
    branchIn = '0;
    loadDone = '0;
    privMode = 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    fpOpReq <= 1'b1;
    axiRead(pmfis_pkg::REG_CTRL, 32'h3, pmfis_pkg::CTRL_RESET, pmfis_pkg::RESP_OKAY);
    axiRead(8'h20, 32'hffff_ffff, 32'h0, pmfis_pkg::RESP_SLVERR);
    axiWrite(pmfis_pkg::REG_STATUS, 32'h1, pmfis_pkg::RESP_SLVERR);
    retire(pmfis_pkg::PMFIS_IRW_FPCTL, 1'b1, 32'hdead_beef);
    axiRead(pmfis_pkg::REG_FPCTL, 32'hffff_ffff, 32'h0, pmfis_pkg::RESP_OKAY);
    retire(pmfis_pkg::PMFIS_IRW_FPCTL, 1'b0, 32'h0000_00a5);
    for (int i = 0; i < 5; i++) begin
      @(negedge clock);
      chk1(fpOpGo, i == 4);
    end
    axiRead(pmfis_pkg::REG_FPCTL, 32'hffff_ffff, 32'ha5, pmfis_pkg::RESP_OKAY);
    chk1(specExitAllowed, 1'b1);
    fetchOutstanding <= 1'b1;
    retire(pmfis_pkg::PMFIS_IRW_IFLUSH, 1'b0, 32'h0);
    stallRet(1'b0);
    flushes(32'h0);
    axiRead(pmfis_pkg::REG_STATUS, 32'h1, 32'h1, pmfis_pkg::RESP_OKAY);
    fetchOutstanding <= 1'b0;
    flushes(32'h1);
    retire(pmfis_pkg::PMFIS_IRW_IFLUSH, 1'b0, 32'h0);
    retire(pmfis_pkg::PMFIS_IRW_MAPCLR, 1'b0, 32'h0);
    stallRet(1'b0);
    flushes(32'h0);
    retire(pmfis_pkg::PMFIS_IRW_IFLUSH, 1'b0, 32'h0);
    stallRet(1'b0);
    flushes(32'h1);
    for (int i = 0; i < 2; i++) begin
      pmfis_pkg::pmfis_irw_t a;
      a = i ? pmfis_pkg::PMFIS_IRW_IS_A : pmfis_pkg::PMFIS_IRW_ASN_A;
      retire(a, 1'b0, 32'h7);
      stallRet(1'b1);
      retire(a, 1'b0, 32'h7);
      retire(pmfis_pkg::pmfis_irw_t'(a + 4'h1), 1'b0, 32'h7);
      stallRet(1'b0);
    end
    retire(pmfis_pkg::PMFIS_IRW_ITLBIA, 1'b0, 32'h0);
    axiRead(pmfis_pkg::REG_STATUS, 32'h2, 32'h2, pmfis_pkg::RESP_OKAY);
    for (int s = 3; s < 6; s++) begin
      br(pmfis_pkg::PMFIS_BR_COND, s[2:0], 1'b0, 1'b0);
      chk1(predictOut.taken, s == 3);
    end
    br(pmfis_pkg::PMFIS_BR_COND, 3'h0, 1'b1, 1'b0);
    chk1(predictOut.taken, 1'b0);
    br(pmfis_pkg::PMFIS_BR_UJUMP, 3'h0, 1'b0, 1'b0);
    chk1(predictOut.mispredict, 1'b1);
    br(pmfis_pkg::PMFIS_BR_PRET, 3'h0, 1'b0, 1'b1);
    chk1(predictOut.mispredict, 1'b1);
    for (int k = 4; k < 7; k++) begin
      br(pmfis_pkg::pmfis_br_t'(k[3:0]), 3'h0, 1'b0, 1'b1);
      check(predictOut.target, 32'h1000_0003);
    end
    @(posedge clock);
    privMode <= 1'b0;
    @(negedge clock);
    check(predictOut.target, 32'h0);
    @(posedge clock);
    privMode <= 1'b1;
    branchIn <= '0;
    trapEnter <= 1'b1;
    exceptionAddress <= 32'h0000_2000;
    @(posedge clock);
    trapEnter <= 1'b0;
    axiRead(pmfis_pkg::REG_RASTOP, 32'hffff_ffff, 32'h2000, pmfis_pkg::RESP_OKAY);
    br(pmfis_pkg::PMFIS_BR_PRET, 3'h0, 1'b0, 1'b0);
    chk1(predictOut.fromStack, 1'b1);
    check(predictOut.target, 32'h2000);
    @(posedge clock);
    branchIn <= '0;
    irMoveReq <= 1'b1;
    loadReq <= 1'b1;
    storeBubbleBusy <= 1'b1;
    @(negedge clock);
    chk1(irMoveIssue, 1'b0);
    chk1(loadIssue, 1'b1);
    @(posedge clock);
    storeBubbleBusy <= 1'b0;
    loadBubbleBusy <= 1'b1;
    @(negedge clock);
    chk1(irMoveIssue, 1'b1);
    chk1(loadIssue, 1'b0);
    ld(1'b0, 32'h5);
    axiRead(pmfis_pkg::REG_DCCTL, 32'hffff_ffff, 32'h5, pmfis_pkg::RESP_OKAY);
    ld(1'b1, 32'h9);
    axiRead(pmfis_pkg::REG_FAULT, 32'hffff_ffff, 32'h5, pmfis_pkg::RESP_OKAY);
    axiWrite(pmfis_pkg::REG_CTRL, 32'h2, pmfis_pkg::RESP_OKAY);
    icacheHit <= 1'b1;
    @(negedge clock);
    chk1(supplyValid, 1'b0);
    @(posedge clock);
    streamHit <= 1'b1;
    @(negedge clock);
    chk1(supplyValid, 1'b1);
    conclude();
  end
endmodule
`default_nettype wire
